// ==== hw/bbe_map.svh ====
// Register offsets, field positions, reset values, opcode patterns and timing for the execution unit
`ifndef BBE_MAP_SVH
`define BBE_MAP_SVH

// Register byte offsets on the AXI4-Lite slave
`define BBE_OFF_INSTR      8'h00
`define BBE_OFF_CTRL       8'h04
`define BBE_OFF_PC         8'h08
`define BBE_OFF_FLAGS      8'h0c
`define BBE_OFF_BANK       8'h10
`define BBE_OFF_STATUS     8'h14
`define BBE_OFF_DADDR      8'h18
`define BBE_OFF_DATA       8'h1c

// Field positions
`define BBE_CTRL_TWO_WORD  0
`define BBE_FLAG_ZERO      0
`define BBE_FLAG_OVF       1
`define BBE_ST_BUSY        0
`define BBE_ST_CYC_LO      1
`define BBE_ST_CYC_HI      2
`define BBE_ST_TAKEN       3
`define BBE_ST_SKIP        4
`define BBE_ST_UNSUP       5
`define BBE_ST_DROP        6

// Reset values
`define BBE_RST_INSTR      16'h0000
`define BBE_RST_PC         21'h000000
`define BBE_RST_BANK       4'h0
`define BBE_RST_DADDR      12'h000

// Bank used when the access bit is clear
`define BBE_ACCESS_BANK    4'h0

// Opcode patterns
`define BBE_PAT_NOOVF      8'he5
`define BBE_PAT_NONZERO    8'he1
`define BBE_PAT_JUMP       5'h1a
`define BBE_PAT_SETBIT     4'h8
`define BBE_PAT_TESTCLR    4'hb

// Timing: four phases per instruction cycle, one program word is two bytes
`define BBE_Q2             2'h1
`define BBE_Q3             2'h2
`define BBE_Q4             2'h3
`define BBE_WORD           21'h000002

// AXI responses
`define BBE_RESP_OKAY      2'h0
`define BBE_RESP_SLVERR    2'h2

`endif

// ==== hw/bbe_pkg.sv ====
// Types shared by the execution unit files
package bbe_pkg;

  typedef enum logic [2:0] {
    OP_NONE                   = 3'b000,
    OP_BRANCH_IF_NO_OVERFLOW  = 3'b001,
    OP_BRANCH_IF_NONZERO      = 3'b010,
    OP_RELATIVE_JUMP          = 3'b011,
    OP_SET_FILE_BIT           = 3'b100,
    OP_TEST_BIT_SKIP_CLEAR    = 3'b101
  } bbe_op_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP  = 2'b10
  } bbe_state_e;

  typedef struct packed {
    bbe_op_e     op;
    logic [20:0] disp;
    logic [2:0]  bit_sel;
    logic        access;
    logic [7:0]  faddr;
  } bbe_dec_s;

endpackage

// ==== hw/bbe_decode.sv ====
// Instruction decoder for the branch and bit-operation subset
`include "bbe_map.svh"

module bbe_decode (
  input  wire logic [15:0]      instr,
  output bbe_pkg::bbe_dec_s     dec
);

  // Doubled, sign-extended word displacement
  function automatic logic [20:0] twice_off(input logic [10:0] n);
    twice_off = {{9{n[10]}}, n, 1'b0};
  endfunction

  always_comb begin
    dec         = '0;
    dec.op      = bbe_pkg::OP_NONE;
    dec.bit_sel = instr[11:9];
    dec.access  = instr[8];
    dec.faddr   = instr[7:0];
    if (instr[15:8] == `BBE_PAT_NOOVF) begin
      dec.op   = bbe_pkg::OP_BRANCH_IF_NO_OVERFLOW;
      dec.disp = twice_off({{3{instr[7]}}, instr[7:0]});
    end else if (instr[15:8] == `BBE_PAT_NONZERO) begin
      dec.op   = bbe_pkg::OP_BRANCH_IF_NONZERO;
      dec.disp = twice_off({{3{instr[7]}}, instr[7:0]});
    end else if (instr[15:11] == `BBE_PAT_JUMP) begin
      dec.op   = bbe_pkg::OP_RELATIVE_JUMP;
      dec.disp = twice_off(instr[10:0]);
    end else if (instr[15:12] == `BBE_PAT_SETBIT) begin
      dec.op = bbe_pkg::OP_SET_FILE_BIT;
    end else if (instr[15:12] == `BBE_PAT_TESTCLR) begin
      dec.op = bbe_pkg::OP_TEST_BIT_SKIP_CLEAR;
    end
  end

endmodule

// ==== hw/bbe_data_ram.sv ====
// Banked data memory with one write port and two read ports
module bbe_data_ram (
  input  wire logic        aclk,
  input  wire logic        we,
  input  wire logic [11:0] waddr,
  input  wire logic [7:0]  wdata,
  input  wire logic [11:0] raddr_a,
  output logic      [7:0]  rdata_a,
  input  wire logic [11:0] raddr_b,
  output logic      [7:0]  rdata_b
);

  // Sixteen banks of 256 bytes; contents are not cleared by reset
  logic [7:0] mem [0:4095];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule

// ==== hw/bbe_exec_top.sv ====
// Branch and bit-operation execution unit behind an AXI4-Lite register slave
`include "bbe_map.svh"

module bbe_exec_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic      [1:0]  bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic      [31:0] rdata,
  output logic      [1:0]  rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  logic [7:0]  awaddr_q;
  logic        aw_got_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        w_got_q;
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [1:0]  rresp_q;
  logic [31:0] rdata_q;
  logic [15:0] instr_q;
  logic        two_word_q;
  logic [20:0] pc_q;
  logic        zero_q;
  logic        ovf_q;
  logic [3:0]  bank_q;
  logic [11:0] daddr_q;
  bbe_pkg::bbe_state_e state_q;
  logic [1:0]  phase_q;
  logic [1:0]  nops_q;
  logic [7:0]  rd_q;
  logic [7:0]  res_q;
  logic        take_q;
  logic [1:0]  cyc_q;
  logic        taken_q;
  logic        skipped_q;
  logic        unsup_q;
  logic        drop_q;
  bbe_pkg::bbe_dec_s dec;
  logic [7:0]  wr_addr;
  logic [32:0] wr_look;
  logic [32:0] rd_look;
  logic [31:0] wr_val;
  logic        wr_fire;
  logic        wr_ok;
  logic        busy;
  logic        start;
  logic        q4;
  logic        cond;
  logic [20:0] pc_d;
  logic [1:0]  nops_d;
  logic [3:0]  bank_sel;
  logic [11:0] exec_addr;
  logic        exec_we;
  logic        sw_we;
  logic [7:0]  mem_rdata_a;
  logic [7:0]  mem_rdata_b;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction
  // Register view, top bit marks a mapped offset
  function automatic logic [32:0] reg_read(input logic [7:0] a);
    case (a)
      `BBE_OFF_INSTR:  reg_read = {1'b1, 16'h0000, instr_q};
      `BBE_OFF_CTRL:   reg_read = {1'b1, 31'h00000000, two_word_q};
      `BBE_OFF_PC:     reg_read = {1'b1, 11'h000, pc_q};
      `BBE_OFF_FLAGS:  reg_read = {1'b1, 30'h00000000, ovf_q, zero_q};
      `BBE_OFF_BANK:   reg_read = {1'b1, 28'h0000000, bank_q};
      `BBE_OFF_STATUS: reg_read = {1'b1, 25'h0000000, drop_q, unsup_q, skipped_q, taken_q, cyc_q, busy};
      `BBE_OFF_DADDR:  reg_read = {1'b1, 20'h00000, daddr_q};
      `BBE_OFF_DATA:   reg_read = {1'b1, 24'h000000, mem_rdata_b};
      default:         reg_read = '0;
    endcase
  endfunction

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rresp   = rresp_q;
  assign rdata   = rdata_q;
  assign wr_addr = {awaddr_q[7:2], 2'b00};
  // Processes, so that the registers read inside the function are followed as well
  always_comb wr_look = reg_read(wr_addr);
  always_comb rd_look = reg_read({araddr[7:2], 2'b00});
  assign wr_val  = merge(wr_look[31:0], wdata_q, wstrb_q);
  assign wr_fire = aw_got_q & w_got_q & ~bvalid_q;
  assign wr_ok   = wr_fire & wr_look[32];
  assign busy    = (state_q != bbe_pkg::ST_IDLE);
  assign start   = wr_ok & (wr_addr == `BBE_OFF_INSTR) & ~busy;
  assign q4      = (state_q == bbe_pkg::ST_EXEC) && (phase_q == `BBE_Q4);
  bbe_decode u_decode (
    .instr (instr_q),
    .dec   (dec)
  );
  assign bank_sel  = dec.access ? bank_q : `BBE_ACCESS_BANK;
  assign exec_addr = {bank_sel, dec.faddr};
  assign exec_we   = q4 && (dec.op == bbe_pkg::OP_SET_FILE_BIT);
  // Software data writes are held off while an instruction runs, so the ports never collide
  assign sw_we     = wr_ok & (wr_addr == `BBE_OFF_DATA) & ~busy;
  bbe_data_ram u_ram (
    .aclk    (aclk),
    .we      (exec_we | sw_we),
    .waddr   (exec_we ? exec_addr : daddr_q),
    .wdata   (exec_we ? res_q : wr_val[7:0]),
    .raddr_a (exec_addr),
    .rdata_a (mem_rdata_a),
    .raddr_b (daddr_q),
    .rdata_b (mem_rdata_b)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b0;
      awaddr_q  <= 8'h00;
    end else if (awvalid && awready_q) begin
      awready_q <= 1'b0;
      aw_got_q  <= 1'b1;
      awaddr_q  <= awaddr;
    end else if (wr_fire) begin
      aw_got_q <= 1'b0;
    end else if (!aw_got_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b0;
      wdata_q  <= 32'h00000000;
      wstrb_q  <= 4'h0;
    end else if (wvalid && wready_q) begin
      wready_q <= 1'b0;
      w_got_q  <= 1'b1;
      wdata_q  <= wdata;
      wstrb_q  <= wstrb;
    end else if (wr_fire) begin
      w_got_q <= 1'b0;
    end else if (!w_got_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `BBE_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_look[32] ? `BBE_RESP_OKAY : `BBE_RESP_SLVERR;
    end else if (bready && bvalid_q) begin
      bvalid_q <= 1'b0;
    end
  end

  // Read channel, answered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `BBE_RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end else if (arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= rd_look[31:0];
      rresp_q   <= rd_look[32] ? `BBE_RESP_OKAY : `BBE_RESP_SLVERR;
    end else if (rready && rvalid_q) begin
      rvalid_q <= 1'b0;
    end else if (!rvalid_q && !arready_q) begin
      arready_q <= 1'b1;
    end
  end

  // Plain control registers; flags are software-owned and execution never writes them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      two_word_q <= 1'b0;
      zero_q     <= 1'b0;
      ovf_q      <= 1'b0;
      bank_q     <= `BBE_RST_BANK;
      daddr_q    <= `BBE_RST_DADDR;
    end else if (wr_ok) begin
      case (wr_addr)
        `BBE_OFF_CTRL:  two_word_q <= wr_val[`BBE_CTRL_TWO_WORD];
        `BBE_OFF_FLAGS: begin
          zero_q <= wr_val[`BBE_FLAG_ZERO];
          ovf_q  <= wr_val[`BBE_FLAG_OVF];
        end
        `BBE_OFF_BANK:  bank_q  <= wr_val[3:0];
        `BBE_OFF_DADDR: daddr_q <= wr_val[11:0];
        default: ;
      endcase
    end
  end

  // Branch condition, evaluated in the third phase
  always_comb begin
    cond = 1'b0;
    case (dec.op)
      bbe_pkg::OP_BRANCH_IF_NO_OVERFLOW: cond = ~ovf_q;
      bbe_pkg::OP_BRANCH_IF_NONZERO:     cond = ~zero_q;
      bbe_pkg::OP_RELATIVE_JUMP:         cond = 1'b1;
      bbe_pkg::OP_TEST_BIT_SKIP_CLEAR:   cond = ~rd_q[dec.bit_sel];
      default:                           cond = 1'b0;
    endcase
  end

  always_comb begin
    pc_d   = pc_q + `BBE_WORD;
    nops_d = 2'h0;
    case (dec.op)
      bbe_pkg::OP_BRANCH_IF_NO_OVERFLOW,
      bbe_pkg::OP_BRANCH_IF_NONZERO,
      bbe_pkg::OP_RELATIVE_JUMP: begin
        if (take_q) begin
          pc_d   = pc_q + `BBE_WORD + dec.disp;
          nops_d = 2'h1;
        end
      end
      bbe_pkg::OP_TEST_BIT_SKIP_CLEAR: begin
        if (take_q && two_word_q) begin
          pc_d   = pc_q + `BBE_WORD + `BBE_WORD + `BBE_WORD;
          nops_d = 2'h2;
        end else if (take_q) begin
          pc_d   = pc_q + `BBE_WORD + `BBE_WORD;
          nops_d = 2'h1;
        end
      end
      default: ;
    endcase
  end

  // Program counter: software loads it only while idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc_q <= `BBE_RST_PC;
    end else if (q4) begin
      pc_q <= pc_d;
    end else if (wr_ok && (wr_addr == `BBE_OFF_PC) && !busy) begin
      pc_q <= wr_val[20:0];
    end
  end

  // Sequencer: four phases per cycle, then any no-op cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= bbe_pkg::ST_IDLE;
      phase_q <= 2'h0;
      nops_q  <= 2'h0;
    end else begin
      case (state_q)
        bbe_pkg::ST_IDLE: begin
          phase_q <= 2'h0;
          if (start) begin
            state_q <= bbe_pkg::ST_EXEC;
          end
        end
        bbe_pkg::ST_EXEC: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == `BBE_Q4) begin
            nops_q  <= nops_d;
            state_q <= (nops_d != 2'h0) ? bbe_pkg::ST_NOP : bbe_pkg::ST_IDLE;
          end
        end
        bbe_pkg::ST_NOP: begin
          phase_q <= phase_q + 2'h1;
          if (phase_q == `BBE_Q4) begin
            nops_q <= nops_q - 2'h1;
            if (nops_q == 2'h1) begin
              state_q <= bbe_pkg::ST_IDLE;
            end
          end
        end
        default: state_q <= bbe_pkg::ST_IDLE;
      endcase
    end
  end

  // Datapath: read in the second phase, modify in the third, write back in the fourth
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      instr_q <= `BBE_RST_INSTR;
      rd_q    <= 8'h00;
      res_q   <= 8'h00;
      take_q  <= 1'b0;
    end else begin
      if (start) begin
        instr_q <= wr_val[15:0];
      end
      if (state_q == bbe_pkg::ST_EXEC && phase_q == `BBE_Q2) begin
        rd_q <= mem_rdata_a;
      end
      if (state_q == bbe_pkg::ST_EXEC && phase_q == `BBE_Q3) begin
        take_q <= cond;
        res_q  <= rd_q | (8'h01 << dec.bit_sel);
      end
    end
  end

  // Result of the last instruction, plus a sticky flag for starts refused while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cyc_q     <= 2'h0;
      taken_q   <= 1'b0;
      skipped_q <= 1'b0;
      unsup_q   <= 1'b0;
      drop_q    <= 1'b0;
    end else begin
      if (q4) begin
        cyc_q     <= nops_d + 2'h1;
        taken_q   <= take_q && (dec.op != bbe_pkg::OP_TEST_BIT_SKIP_CLEAR); // Set-bit and no-op never take
        skipped_q <= take_q && (dec.op == bbe_pkg::OP_TEST_BIT_SKIP_CLEAR);
        unsup_q   <= (dec.op == bbe_pkg::OP_NONE);
      end
      // A refused start in the same cycle as a clear keeps the flag set
      if (wr_ok && (wr_addr == `BBE_OFF_INSTR) && busy) begin
        drop_q <= 1'b1;
      end else if (wr_ok && (wr_addr == `BBE_OFF_STATUS) && wr_val[`BBE_ST_DROP]) begin
        drop_q <= 1'b0;
      end
    end
  end
endmodule

// ==== test/bbe_exec_props.sv ====
// Register slave handshake and flag-preservation checker for the execution unit
`include "bbe_map.svh"

module bbe_exec_props (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0]  wstrb,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic        w_lane0_q;
  logic [1:0]  flags_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) aw_addr_q <= 8'h00;
    else if (awvalid && awready) aw_addr_q <= awaddr;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_data_q  <= 32'h0;
      w_lane0_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_data_q  <= wdata;
      w_lane0_q <= wstrb[0];
    end
  end

  // Shadow of what software last wrote; execution must never alter it
  always_ff @(posedge aclk) begin
    if (!aresetn) flags_q <= 2'h0;
    else if (bvalid && bready && aw_addr_q == `BBE_OFF_FLAGS && w_lane0_q) flags_q <= w_data_q[1:0];
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_read_resp: assert property (arvalid && arready |=>
    rvalid && rresp == (($past(araddr) >= 8'h20) ? `BBE_RESP_SLVERR : `BBE_RESP_OKAY))
    else $error("read response code wrong for address");
  a_unmapped_zero: assert property (arvalid && arready && araddr >= 8'h20 |=> rdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  a_write_resp: assert property ($rose(bvalid) |->
    bresp == ((aw_addr_q >= 8'h20) ? `BBE_RESP_SLVERR : `BBE_RESP_OKAY))
    else $error("write response code wrong for address");
  a_aw_blocked: assert property (bvalid |-> !awready && !wready)
    else $error("write channel ready while response pending");
  a_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address ready while data pending");
  a_b_release: assert property (bvalid && bready |=> !bvalid ##1 (awready && wready))
    else $error("write response or ready recovery out of step");
  a_ar_release: assert property (rvalid && rready |=> !rvalid ##1 arready)
    else $error("read data or ready recovery out of step");
  a_flags_kept: assert property (
    arvalid && arready && araddr == `BBE_OFF_FLAGS |=> rdata[1:0] == flags_q)
    else $error("status flags differ from last software write");
endmodule

bind bbe_exec_top bbe_exec_props props_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rresp(rresp), .rvalid(rvalid), .rready(rready));

// ==== test/branch_and_bit_op_exec_tb.sv ====
// Register-level testbench for the branch and bit-operation execution unit
`include "bbe_map.svh"

module branch_and_bit_op_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  int          n_mismatch = 0;
  int          n_compared = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  localparam logic [20:0] base_pc = 21'h001000;

  always #10 aclk = ~aclk;

  bbe_exec_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Address and data are offered together and each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    wvalid <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic w_ok(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, `BBE_RESP_OKAY});
  endtask

  task automatic r_chk(input logic [7:0] a, input logic [31:0] exp);
    rdr(a, rd, rs);
    chk(rd, exp);
  endtask

  // Polling is bounded so a stuck busy flag shows up as a mismatch
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      rdr(`BBE_OFF_STATUS, rd, rs);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (rd[0] !== 1'b0) n_mismatch++;
  endtask

  task automatic set_mem(input logic [11:0] a, input logic [7:0] v);
    w_ok(`BBE_OFF_DADDR, {20'h0, a});
    w_ok(`BBE_OFF_DATA, {24'h0, v});
  endtask

  task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
    w_ok(`BBE_OFF_DADDR, {20'h0, a});
    r_chk(`BBE_OFF_DATA, {24'h0, v});
  endtask

  // est holds skip, taken and the two-bit cycle count of the finished instruction
  task automatic run(input logic [15:0] ins, input logic [1:0] fl, input logic ct, input logic [20:0] epc,
                     input logic [3:0] est);
    w_ok(`BBE_OFF_FLAGS, {30'h0, fl});
    w_ok(`BBE_OFF_CTRL, {31'h0, ct});
    w_ok(`BBE_OFF_PC, {11'h0, base_pc});
    w_ok(`BBE_OFF_INSTR, {16'h0, ins});
    wait_idle();
    chk(rd & 32'h1f, {27'h0, est, 1'b0});
    r_chk(`BBE_OFF_PC, {11'h0, epc});
    r_chk(`BBE_OFF_FLAGS, {30'h0, fl});
  endtask

  initial begin
    #400000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      r_chk(8'(4 * i), 32'h0);
    end
    run(16'he17f, 2'b00, 1'b0, base_pc + 21'd2 + 21'd254, 4'b0110);
    run(16'he17f, 2'b01, 1'b0, base_pc + 21'd2, 4'b0001);
    run(16'he180, 2'b10, 1'b0, base_pc + 21'd2 - 21'd256, 4'b0110);
    run(16'he505, 2'b01, 1'b0, base_pc + 21'd2 + 21'd10, 4'b0110);
    run(16'he505, 2'b10, 1'b0, base_pc + 21'd2, 4'b0001);
    run(16'hd3ff, 2'b00, 1'b0, base_pc + 21'd2 + 21'd2046, 4'b0110);
    run(16'hd400, 2'b11, 1'b0, base_pc + 21'd2 - 21'd2048, 4'b0110);
    run(16'he000, 2'b01, 1'b0, base_pc + 21'd2, 4'b0001);
    rdr(`BBE_OFF_STATUS, rd, rs);
    chk(rd & 32'h20, 32'h20);
    w_ok(`BBE_OFF_BANK, 32'h3);
    set_mem(12'h020, 8'h0a);
    set_mem(12'h320, 8'h0a);
    run(16'h8e20, 2'b00, 1'b0, base_pc + 21'd2, 4'b0001);
    mem_chk(12'h020, 8'h8a);
    mem_chk(12'h320, 8'h0a);
    run(16'h8120, 2'b11, 1'b0, base_pc + 21'd2, 4'b0001);
    mem_chk(12'h320, 8'h0b);
    mem_chk(12'h020, 8'h8a);
    run(16'hbe20, 2'b00, 1'b0, base_pc + 21'd2, 4'b0001);
    run(16'hb420, 2'b00, 1'b0, base_pc + 21'd4, 4'b1010);
    run(16'hb420, 2'b01, 1'b1, base_pc + 21'd6, 4'b1011);
    run(16'hbf20, 2'b00, 1'b0, base_pc + 21'd4, 4'b1010);
    // A second start while busy must be dropped, leaving the first jump intact
    w_ok(`BBE_OFF_PC, {11'h0, base_pc});
    w_ok(`BBE_OFF_INSTR, 32'h0000d001);
    w_ok(`BBE_OFF_INSTR, 32'h0000e1ff);
    wait_idle();
    chk(rd & 32'h40, 32'h40);
    r_chk(`BBE_OFF_PC, {11'h0, base_pc + 21'd4});
    w_ok(`BBE_OFF_STATUS, 32'h40);
    rdr(`BBE_OFF_STATUS, rd, rs);
    chk(rd & 32'h40, 32'h0);
    wr(8'h20, 32'h1, rs);
    chk({30'h0, rs}, {30'h0, `BBE_RESP_SLVERR});
    rdr(8'h24, rd, rs);
    chk({30'h0, rs}, {30'h0, `BBE_RESP_SLVERR});
    chk(rd, 32'h0);
    conclude();
  end
endmodule
